/* src/hbp_host_port.sv */
// Purpose: Separate-strobe 8-bit host bus port of a serial controller.
// Assumes: Strobes and pins synchronous to CLOCK; one clock domain.
// Notes: Register contents live outside, save a copy of modem control kept here; this block moves bytes to and from them.
// Behaviour
// - Read strobe fall reads selected register onto bus
// - High read strobe equals low one inverted
// - Write begins on fall, stores on trailing edge
// - High write strobe equals low one inverted
// - Respond only when all three selects active
// - Interrupt high when any source pending
// - Modem control bit five picks interrupt drive
// - Address strobe fall latches selects and address
// - Tied-low address strobe still latches at start
// - Transmit room output reflects transmit holding status
// - Three address lines pick the register
// - Data bus bidirectional, driven only in reads
`timescale 1ns/1ps
`include "hbp_defines.svh"
module hbp_host_port
	import hbp_pkg::*;
#(
	parameter int DATA_W = `HBP_DATA_W,
	parameter int ADDR_W = `HBP_ADDR_W
)
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic READ_STROBE_LOW_N,
	input wire logic READ_STROBE_HIGH,
	input wire logic WRITE_STROBE_LOW_N,
	input wire logic WRITE_STROBE_HIGH,
	input wire logic SELECT_A_HIGH,
	input wire logic SELECT_B_HIGH,
	input wire logic SELECT_C_LOW_N,
	input wire logic ADDR_LATCH_STROBE_LOW_N,
	input wire logic [ADDR_W-1:0] REG_SELECT_LINES,
	input wire logic [DATA_W-1:0] DATA_IN,
	output logic [DATA_W-1:0] DATA_OUT,
	output logic DATA_OE,
	input wire logic TX_IRQ_PEND,
	input wire logic RX_IRQ_PEND,
	input wire logic LINE_IRQ_PEND,
	input wire logic MODEM_IRQ_PEND,
	output logic INT_OUT,
	output logic INT_OE,
	input wire logic TX_HOLD_ROOM,
	output logic TX_ROOM_LOW_N,
	output logic [ADDR_W-1:0] REG_ADDR,
	output logic REG_RD,
	input wire logic [DATA_W-1:0] REG_RD_DATA,
	output logic REG_WR,
	output logic [DATA_W-1:0] REG_WR_DATA
);
	hbp_state_t state_r, state_nxt;
	logic rd_q_r, wr_q_r, lat_q_r;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic sel_r, sel_nxt;
	logic [DATA_W-1:0] modem_ctl_r, modem_ctl_nxt;
	logic [ADDR_W-1:0] reg_addr_nxt;
	logic [DATA_W-1:0] reg_wr_data_nxt, data_out_nxt;
	logic data_oe_nxt, int_oe_nxt, tx_room_nxt;

	// Either polarity of a read or write strobe counts as active; the address strobe is active low only
	wire rd_act = ~READ_STROBE_LOW_N | READ_STROBE_HIGH;
	wire wr_act = ~WRITE_STROBE_LOW_N | WRITE_STROBE_HIGH;
	wire lat_act = ~ADDR_LATCH_STROBE_LOW_N;
	wire cs_all = SELECT_A_HIGH & SELECT_B_HIGH & ~SELECT_C_LOW_N;
	// One action per pulse: only the first active sample starts an access
	wire rd_rise = rd_act & ~rd_q_r;
	wire wr_rise = wr_act & ~wr_q_r;
	wire wr_fall = ~wr_act & wr_q_r;
	wire lat_edge = lat_act & ~lat_q_r;
	wire strobe_start = (rd_rise | wr_rise) & (state_r == HBP_IDLE);
	// Explicit strobe edge latches; a tied-low strobe latches at access start,
	// so the host may drop the address right after its strobe edge
	wire latch_now = lat_edge | (lat_act & lat_q_r & strobe_start);
	wire sel_eff = latch_now ? cs_all : sel_r;
	wire [ADDR_W-1:0] addr_eff = latch_now ? REG_SELECT_LINES : addr_r;
	wire go_rd = rd_rise & sel_eff & (state_r == HBP_IDLE);
	wire go_wr = wr_rise & sel_eff & (state_r == HBP_IDLE);
	// The byte is stored on the trailing edge, from data still on the bus
	wire do_wr = (state_r == HBP_WRITE) & wr_fall;
	wire end_rd = (state_r == HBP_READ) & ~rd_act;
	wire modem_ctl_hit = do_wr & (addr_r == ADDR_W'(`HBP_MODEM_CTL_ADDR));
	wire irq_any = TX_IRQ_PEND | RX_IRQ_PEND | LINE_IRQ_PEND | MODEM_IRQ_PEND;
	wire int_open = modem_ctl_r[`HBP_MODEM_CTL_OS_BIT];

	// Access sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			HBP_IDLE: begin
				if (go_rd)
					state_nxt = HBP_READ;
				else if (go_wr)
					state_nxt = HBP_WRITE;
			end
			HBP_READ: begin
				if (end_rd)
					state_nxt = HBP_IDLE;
			end
			HBP_WRITE: begin
				if (wr_fall)
					state_nxt = HBP_IDLE;
			end
		endcase
	end

	// Next values; each output below is a plain flip-flop
	assign addr_nxt = addr_eff;
	assign sel_nxt = sel_eff;
	assign reg_addr_nxt = (go_rd | go_wr) ? addr_eff : REG_ADDR;
	assign reg_wr_data_nxt = do_wr ? DATA_IN : REG_WR_DATA;
	assign data_out_nxt = REG_RD ? REG_RD_DATA : DATA_OUT;
	assign data_oe_nxt = (state_nxt == HBP_READ);
	assign modem_ctl_nxt = modem_ctl_hit ? DATA_IN : modem_ctl_r;
	// Open-source mode lets the pin float while nothing is pending
	assign int_oe_nxt = ~int_open | irq_any;
	assign tx_room_nxt = ~TX_HOLD_ROOM;

	// Strobe history for edge detection
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rd_q_r <= `HBP_BIT_CLR;
			wr_q_r <= `HBP_BIT_CLR;
			lat_q_r <= `HBP_BIT_CLR;
		end else begin
			rd_q_r <= rd_act;
			wr_q_r <= wr_act;
			lat_q_r <= lat_act;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			state_r <= HBP_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			addr_r <= ADDR_W'(`HBP_SEL_ZERO);
		else
			addr_r <= addr_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			sel_r <= `HBP_BIT_CLR;
		else
			sel_r <= sel_nxt;
	end

	// Core-side address, strobes and write byte
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			REG_ADDR <= ADDR_W'(`HBP_SEL_ZERO);
		else
			REG_ADDR <= reg_addr_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			REG_RD <= `HBP_BIT_CLR;
		else
			REG_RD <= go_rd;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			REG_WR <= `HBP_BIT_CLR;
		else
			REG_WR <= do_wr;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			REG_WR_DATA <= DATA_W'(`HBP_BYTE_ZERO);
		else
			REG_WR_DATA <= reg_wr_data_nxt;
	end

	// Host data bus drive and modem control register
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			DATA_OUT <= DATA_W'(`HBP_BYTE_ZERO);
		else
			DATA_OUT <= data_out_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			DATA_OE <= `HBP_BIT_CLR;
		else
			DATA_OE <= data_oe_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			modem_ctl_r <= DATA_W'(`HBP_MODEM_CTL_RST);
		else
			modem_ctl_r <= modem_ctl_nxt;
	end

	// Interrupt pin and transmit room status
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			INT_OUT <= `HBP_BIT_CLR;
		else
			INT_OUT <= irq_any;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			INT_OE <= `HBP_BIT_SET;
		else
			INT_OE <= int_oe_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			TX_ROOM_LOW_N <= `HBP_BIT_SET;
		else
			TX_ROOM_LOW_N <= tx_room_nxt;
	end
endmodule

/* src/hbp_defines.svh */
// Purpose: Named constants for the host bus port.
// Assumes: Included by bare name.
// Notes: Definitions only.
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH
`define HBP_DATA_W 8
`define HBP_ADDR_W 3
`define HBP_MODEM_CTL_ADDR 3'h4
`define HBP_MODEM_CTL_OS_BIT 5
`define HBP_MODEM_CTL_RST 8'h00
`define HBP_BYTE_ZERO 8'h00
`define HBP_SEL_ZERO 3'h0
`define HBP_BIT_CLR 1'h0
`define HBP_BIT_SET 1'h1
`endif

/* src/hbp_pkg.sv */
// Purpose: Types for the host bus port.
// Assumes: Nothing.
// Notes: Access state enumeration.
package hbp_pkg;
	typedef enum logic [1:0] {HBP_IDLE, HBP_READ, HBP_WRITE} hbp_state_t;
endpackage

/* dv/hbp_chk_checker.sv */
// Purpose: Port checks for hbp_host_port.
// Assumes: Strobes not active together.
// Notes: Bound from the bench.
`timescale 1ns/1ps
module hbp_chk #(
	parameter int DATA_W = 8
)
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic READ_STROBE_LOW_N,
	input wire logic READ_STROBE_HIGH,
	input wire logic WRITE_STROBE_LOW_N,
	input wire logic WRITE_STROBE_HIGH,
	input wire logic DATA_OE,
	input wire logic REG_RD,
	input wire logic REG_WR,
	input wire logic INT_OUT,
	input wire logic INT_OE,
	input wire logic TX_IRQ_PEND,
	input wire logic RX_IRQ_PEND,
	input wire logic LINE_IRQ_PEND,
	input wire logic MODEM_IRQ_PEND,
	input wire logic TX_HOLD_ROOM,
	input wire logic TX_ROOM_LOW_N,
	input wire logic [DATA_W-1:0] DATA_OUT,
	input wire logic [DATA_W-1:0] REG_RD_DATA
);
	wire rd = !READ_STROBE_LOW_N || READ_STROBE_HIGH;
	wire wr = !WRITE_STROBE_LOW_N || WRITE_STROBE_HIGH;
	wire pend = TX_IRQ_PEND || RX_IRQ_PEND || LINE_IRQ_PEND || MODEM_IRQ_PEND;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	sequence s_rd_end; DATA_OE && rd ##1 DATA_OE && !rd; endsequence
	a_rd_once: assert property (REG_RD |=> !REG_RD) else $error("read pulse long");
	a_rd_data: assert property (REG_RD |=> DATA_OUT == $past(REG_RD_DATA)) else $error("rdata");
	a_oe_read: assert property (DATA_OE |-> $past(rd)) else $error("bus driven");
	a_oe_drop: assert property (s_rd_end |=> !DATA_OE) else $error("bus held");
	a_wr_trail: assert property (REG_WR |-> $past(wr, 2) && !$past(wr)) else $error("wr");
	a_wr_early: assert property (wr |-> !REG_WR) else $error("early store");
	a_int_src: assert property ($past(RST_N) |-> INT_OUT == $past(pend)) else $error("int");
	a_int_drive: assert property (INT_OUT |-> INT_OE) else $error("int drive");
	a_tx_room: assert property ($past(RST_N) |-> TX_ROOM_LOW_N == !$past(TX_HOLD_ROOM))
		else $error("tx room");
endmodule

/* dv/hbp_host.sv */
// Purpose: Host processor model on the separate-strobe bus.
// Assumes: Address strobe tied low, except in the latched access.
// Notes: Address is removed as soon as a strobe ends, or as the read strobe starts in the latched access.
`timescale 1ns/1ps
module hbp_host(
	input wire logic CLOCK,
	input wire logic DATA_OE,
	input wire logic [7:0] DATA_OUT,
	output logic READ_STROBE_LOW_N,
	output logic READ_STROBE_HIGH,
	output logic WRITE_STROBE_LOW_N,
	output logic WRITE_STROBE_HIGH,
	output logic SELECT_A_HIGH,
	output logic SELECT_B_HIGH,
	output logic SELECT_C_LOW_N,
	output logic ADDR_LATCH_STROBE_LOW_N,
	output logic [2:0] REG_SELECT_LINES,
	output logic [7:0] DATA_IN
);
	logic [3:0] stb = 4'hA;
	logic [3:0] sel = 4'h2;
	assign {READ_STROBE_LOW_N, READ_STROBE_HIGH, WRITE_STROBE_LOW_N, WRITE_STROBE_HIGH} = stb;
	assign {SELECT_A_HIGH, SELECT_B_HIGH, SELECT_C_LOW_N, ADDR_LATCH_STROBE_LOW_N} = sel;
	initial {REG_SELECT_LINES, DATA_IN} = 11'h0;
	task automatic acc(input logic w, hi, ok, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge CLOCK);
		sel = {ok, 3'h4};
		{REG_SELECT_LINES, DATA_IN} = {a, w ? d : ~d};
		stb = w ? (hi ? 4'hB : 4'h8) : (hi ? 4'hE : 4'h2);
		repeat (4) @(posedge CLOCK);
		@(negedge CLOCK);
		q = DATA_OE ? DATA_OUT : ~DATA_IN;
		stb = 4'hA;
		sel = 4'h2;
		REG_SELECT_LINES = ~a;
		repeat (3) @(negedge CLOCK);
	endtask
	// Read with an explicit address strobe pulse; selects and address go away as the read strobe starts
	task automatic acc_lat(input logic [2:0] a, output logic [7:0] q);
		@(negedge CLOCK);
		sel = 4'h3;
		@(negedge CLOCK);
		sel = 4'hC;
		REG_SELECT_LINES = a;
		@(negedge CLOCK);
		sel = 4'h3;
		REG_SELECT_LINES = ~a;
		stb = 4'h2;
		repeat (4) @(negedge CLOCK);
		q = DATA_OE ? DATA_OUT : 8'h00;
		stb = 4'hA;
		sel = 4'h2;
		repeat (3) @(negedge CLOCK);
	endtask
endmodule

/* dv/hbp_host_port_bench.sv */
// Purpose: Self-checking bench for hbp_host_port.
// Assumes: Core read data is a fixed pattern plus the address.
// Notes: Host model drives the bus.
`timescale 1ns/1ps
module hbp_host_port_bench;
	logic CLOCK = 0, RST_N = 0, READ_STROBE_LOW_N, READ_STROBE_HIGH, WRITE_STROBE_LOW_N;
	logic WRITE_STROBE_HIGH, SELECT_A_HIGH, SELECT_B_HIGH, SELECT_C_LOW_N, DATA_OE, INT_OUT;
	logic ADDR_LATCH_STROBE_LOW_N, INT_OE, TX_ROOM_LOW_N, REG_RD, REG_WR, TX_HOLD_ROOM = 0;
	logic TX_IRQ_PEND = 0, RX_IRQ_PEND = 0, LINE_IRQ_PEND = 0, MODEM_IRQ_PEND = 0;
	logic [2:0] REG_SELECT_LINES, REG_ADDR;
	logic [7:0] DATA_IN, DATA_OUT, REG_RD_DATA, REG_WR_DATA, q;
	logic [10:0] wd;
	int mismatches = 0, tests_run = 0, nrd = 0, nwr = 0;
	assign REG_RD_DATA = {5'h1A, REG_ADDR};
	hbp_host hbp_host_inst(.*);
	hbp_host_port hbp_host_port_inst(.*);
	initial forever #50 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		nrd <= nrd + REG_RD;
		nwr <= nwr + REG_WR;
		if (REG_WR) wd <= {REG_ADDR, REG_WR_DATA};
	end
	task chk(input string n, input logic [10:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task finish_test;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task t_bus;
		for (int a = 0; a < 8; a++) begin
			hbp_host_inst.acc(0, a[0], 1, a[2:0], 8'h00, q);
			chk("rdata", q, {5'h1A, a[2:0]});
			chk("nrd", nrd, a + 1);
			hbp_host_inst.acc(1, a[1], 1, a[2:0], 8'hC3 ^ a[7:0], q);
			chk("wdata", wd, {a[2:0], 8'hC3 ^ a[7:0]});
		end
		chk("nwr", nwr, 8);
	endtask
	task t_desel;
		hbp_host_inst.acc(0, 0, 0, 3'h2, 8'h00, q);
		chk("desel_q", q, 8'h00);
		hbp_host_inst.acc(1, 1, 0, 3'h2, 8'h5A, q);
		chk("nrdwr", {nrd[3:0], nwr[3:0]}, 8'h88);
	endtask
	task t_latch;
		hbp_host_inst.acc_lat(3'h5, q);
		chk("rlat", q, {5'h1A, 3'h5});
		chk("nrdl", nrd, 9);
	endtask
	task t_irq;
		for (int i = 0; i < 4; i++) begin
			@(negedge CLOCK);
			{TX_IRQ_PEND, RX_IRQ_PEND, LINE_IRQ_PEND, MODEM_IRQ_PEND} = 4'h1 << i;
			TX_HOLD_ROOM = i[0];
			@(negedge CLOCK);
			chk("int", {INT_OUT, INT_OE, TX_ROOM_LOW_N}, {2'h3, !i[0]});
		end
		hbp_host_inst.acc(1, 0, 1, 3'h4, 8'h20, q);
		chk("int_os", {INT_OUT, INT_OE}, 2'h3);
		{TX_IRQ_PEND, RX_IRQ_PEND, LINE_IRQ_PEND, MODEM_IRQ_PEND} = 4'h0;
		@(negedge CLOCK);
		chk("int_os", {INT_OUT, INT_OE}, 2'h0);
		hbp_host_inst.acc(1, 0, 1, 3'h4, 8'h00, q);
		chk("int_pp", {INT_OUT, INT_OE}, 2'h1);
	endtask
	initial begin
		repeat (16) @(negedge CLOCK);
		RST_N = 1;
		t_bus;
		t_desel;
		t_latch;
		t_irq;
		finish_test;
	end
	initial begin
		#200000;
		mismatches++;
		finish_test;
	end
endmodule
bind hbp_host_port hbp_chk #(.DATA_W(DATA_W)) hbp_chk_inst(.*);
